/* File: logic/serial_nor_flash_bus_interface.sv */
// serial_nor_flash_bus_interface: device end of the multi-line flash bus
// assumes the array core sits outside behind the memory request ports
// How it works
// RULE1 - capture command, address, data on rising clock
// RULE2 - change output data only on falling clock
// RULE3 - deselected keeps serial output line floating
// RULE4 - idle and deselected gives standby power
// RULE5 - select low enters active power state
// RULE6 - host makes select fall before first command
// RULE7 - line zero inputs, turns around for reads
// RULE8 - line one outputs, inputs for multi programs
// RULE9 - write protect becomes line two in quad
// RULE10 - quad line three disables hold and reset
// RULE11 - host releases lines before device drives
// RULE12 - reset pin low resets, outputs float
// RULE13 - host avoids reset during internal cycles
// RULE14 - 128 sectors of 16 subsectors, 2048 total
// RULE15 - erase subsector, sector or whole array
// RULE16 - volatile lock per 64KB sector
// RULE17 - 64 otp bytes, lockable by otp program
// RULE18 - suspend and resume pause program or erase
// RULE19 - extended, two line and four line protocols
// RULE20 - execute in place reads with address only
// RULE21 - nonvolatile setting makes execute in place default
// RULE22 - volatile config overrides nonvolatile defaults
// RULE23 - hold pauses bus, output floats, input ignored
// RULE24 - config bit 4 disables hold; code uses hold_off, bit 9 of config_t
`timescale 1ns/1ps
module serial_nor_flash_bus_interface
	import flash_bus_pkg::*;
#(
	parameter int unsigned sectors = main_sectors
)(
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire pins_t                pins,
	output drive_t                    drive,
	input  wire config_t              nonvolatile_config_reg,
	input  wire logic                 volatile_valid,
	input  wire config_t              enhanced_volatile_config_reg,
	input  wire logic                 busy,
	output logic                      standby,
	output logic                      mem_req,
	output op_t                       mem_op,
	output erase_t                    erase_kind,
	output logic [addr_bits-1:0]      mem_addr,
	output logic [7:0]                mem_wdata,
	output logic                      otp_space,
	input  wire logic [7:0]           mem_rdata,
	output logic                      suspend,
	output logic [sectors-1:0]        sector_lock,
	output logic                      otp_locked,
	output logic                      in_reset
);
	logic [1:0]  rst_sync;
	logic        rst;
	pins_t       p1;
	pins_t       p;
	logic        sclk_d;
	logic        sclk_rise;
	logic        sclk_fall;
	config_t     cfg;
	logic        hold_active;
	logic        selected;
	phase_t      phase;
	logic [7:0]  cmd;
	logic [23:0] shift;
	logic [5:0]  count;
	logic [1:0]  width;
	logic [7:0]  obyte;
	logic        out_en;
	logic        xip_mode;
	logic        armed;
	logic        started;
	logic [3:0]  dummy_left;
	logic        in_byte;
	logic        is_quad;
	logic        prog_multi;
	logic        obyte_load;
	logic [2:0]  obit;
	localparam int unsigned sector_lsb = $clog2(sector_bytes);
	localparam int unsigned sector_idx = $clog2(sectors);

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst = !rst_sync[1];

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			p1 <= '1;
			p  <= '1;
			sclk_d <= 1'b0;
		end
		else
		begin
			p1 <= pins;
			p  <= p1;
			sclk_d <= p.sclk;
		end
	end

	// volatile copy wins once software loaded it
	assign cfg = volatile_valid ? enhanced_volatile_config_reg
		: nonvolatile_config_reg; // RULE22
	assign is_quad = cfg.protocol == four_line_protocol;
	// four line protocol removes hold and reset while selected; quad commands remove hold only
	assign hold_active = !p.hold_n && !p.select_n && !cfg.hold_off
		&& !(is_quad || width == 2'h2); // RULE23 RULE24 RULE10
	assign in_reset = !p.reset_n && !(is_quad && !p.select_n); // RULE12
	assign selected = !p.select_n && !in_reset; // RULE5
	assign sclk_rise = p.sclk && !sclk_d && selected && !hold_active; // RULE1
	assign sclk_fall = !p.sclk && sclk_d && selected && !hold_active; // RULE2
	assign standby = p.select_n && !busy; // RULE4

	// first select low after reset arms command decode
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			armed <= 1'b0;
		else if (in_reset)
			armed <= 1'b0;
		else if (!p.select_n)
			armed <= 1'b1; // RULE6
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			xip_mode <= 1'b0;
		else if (in_reset)
			xip_mode <= 1'b0;
		else if (p.select_n)
			xip_mode <= cfg.execute_in_place; // RULE21
	end

	function automatic logic [1:0] lane_width(input logic [7:0] c,
		input protocol_t pr);
		logic [1:0] w;
		w = (pr == four_line_protocol) ? 2'h2
			: (pr == two_line_protocol) ? 2'h1 : 2'h0; // RULE19
		case (c)
			cmd_dual_out, cmd_dual_io, cmd_dual_prog, cmd_dual_xprog:
				if (w == 2'h0) w = 2'h1;
			cmd_quad_out, cmd_quad_io, cmd_quad_prog, cmd_quad_xprog:
				w = 2'h2;
			default: w = w;
		endcase
		return w;
	endfunction

	function automatic op_t decode(input logic [7:0] c);
		case (c)
			cmd_read, cmd_fast_read, cmd_dual_out, cmd_dual_io,
			cmd_quad_out, cmd_quad_io, cmd_otp_read: return op_read;
			cmd_page_prog, cmd_dual_prog, cmd_dual_xprog,
			cmd_quad_prog, cmd_quad_xprog, cmd_otp_prog,
			cmd_lock_write: return op_write;
			cmd_sub_erase, cmd_sect_erase, cmd_bulk_erase: return op_erase;
			default: return op_none;
		endcase
	endfunction

	assign prog_multi = cmd == cmd_dual_prog || cmd == cmd_dual_xprog
		|| cmd == cmd_quad_prog || cmd == cmd_quad_xprog; // RULE8

	// serial sequencer; all captures on rising edges
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			phase <= st_idle;
			cmd <= 8'h00;
			shift <= 24'h000000;
			count <= 6'h00;
			width <= 2'h0;
			dummy_left <= 4'h0;
			in_byte <= 1'b0;
			started <= 1'b0;
			mem_wdata <= 8'h00;
		end
		else if (!selected || !armed)
		begin
			phase <= st_idle;
			count <= 6'h00;
			started <= 1'b0;
			in_byte <= 1'b0;
		end
		else
		begin
			in_byte <= 1'b0;
			case (phase)
				st_idle:
				begin
					width <= lane_width(8'h00, cfg.protocol);
					if (xip_mode && !started)
					begin
						cmd <= cmd_fast_read; // RULE20
						width <= is_quad ? 2'h2
							: (cfg.protocol == two_line_protocol ? 2'h1 : 2'h0);
						phase <= st_addr;
					end
					else
						phase <= st_cmd;
					started <= 1'b1;
				end
				st_cmd:
					if (sclk_rise)
					begin
						shift <= {shift[22:0], p.dq_in[0]}; // RULE1
						count <= count + 6'h01;
						if (count == 6'h07)
						begin
							cmd <= {shift[6:0], p.dq_in[0]};
							width <= lane_width({shift[6:0], p.dq_in[0]},
								cfg.protocol);
							count <= 6'h00;
							phase <= st_addr;
						end
					end
				st_addr:
					if (sclk_rise)
					begin
						case (width)
							2'h0: shift <= {shift[22:0], p.dq_in[0]};
							2'h1: shift <= {shift[21:0], p.dq_in[1:0]};
							default: shift <= {shift[19:0], p.dq_in};
						endcase
						count <= count + (6'h01 << width);
						if (count + (6'h01 << width) >= 6'(addr_bits))
						begin
							count <= 6'h00;
							dummy_left <= (cmd == cmd_read) ? 4'h0 : cfg.dummy;
							// zero dummy still latches address
							phase <= st_dummy;
						end
					end
				st_dummy:
					if (dummy_left == 4'h0 || decode(cmd) != op_read)
						phase <= st_data;
					else if (sclk_rise)
						dummy_left <= dummy_left - 4'h1;
				st_data:
					if (sclk_rise && decode(cmd) == op_write)
					begin
						// single line unless a multi line program
						if (prog_multi && width != 2'h0)
							mem_wdata <= (width == 2'h1)
								? {mem_wdata[5:0], p.dq_in[1:0]}
								: {mem_wdata[3:0], p.dq_in}; // RULE8
						else
							mem_wdata <= {mem_wdata[6:0], p.dq_in[0]}; // RULE7
						count <= count + (6'h01 << width);
						if (count + (6'h01 << width) == 6'h08)
						begin
							count <= 6'h00;
							in_byte <= 1'b1;
						end
					end
				default: phase <= st_idle;
			endcase
		end
	end

	// address register held for the memory request
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			mem_addr <= '0;
		else if (phase == st_dummy)
			mem_addr <= shift[addr_bits-1:0];
		else if (in_byte || (phase == st_data && obyte_load))
			mem_addr <= mem_addr + 24'h000001;
	end

	assign obyte_load = sclk_fall && out_en && obit == 3'h0;

	// read path: shift out on falling edges only
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			obyte <= 8'h00;
			obit <= 3'h0;
			out_en <= 1'b0;
		end
		else if (!selected)
		begin
			out_en <= 1'b0;
			obit <= 3'h0;
		end
		else if (phase == st_data && decode(cmd) == op_read)
		begin
			if (sclk_fall)
			begin
				out_en <= 1'b1; // RULE11
				if (obit == 3'h0)
					obyte <= mem_rdata;
				else
					obyte <= obyte << (3'h1 << width); // RULE2
				obit <= obit + (3'h1 << width);
			end
		end
	end

	// line ownership per protocol and command
	always_comb
	begin
		drive = '0;
		if (selected && !hold_active && out_en)
		begin
			case (width)
				2'h0:
				begin
					drive.dq_out[1] = obyte[7];
					drive.dq_oe[1] = 1'b1;
				end
				2'h1:
				begin
					drive.dq_out[1:0] = obyte[7:6]; // RULE7
					drive.dq_oe[1:0] = 2'h3;
				end
				default:
				begin
					drive.dq_out = obyte[7:4]; // RULE9 RULE10
					drive.dq_oe = 4'hf;
				end
			endcase
		end
	end // RULE3 RULE12 RULE23

	// memory requests and erase granularity
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mem_req <= 1'b0;
			mem_op <= op_none;
			erase_kind <= er_sub;
			otp_space <= 1'b0;
			suspend <= 1'b0;
		end
		else
		begin
			mem_req <= 1'b0;
			if (in_byte)
			begin
				mem_req <= 1'b1;
				mem_op <= op_write;
				otp_space <= cmd == cmd_otp_prog; // RULE17
			end
			// one pulse on the last dummy cycle, whatever the count
			else if (phase == st_dummy && dummy_left == 4'h0
				&& decode(cmd) == op_read)
			begin
				mem_req <= 1'b1;
				mem_op <= op_read;
				otp_space <= cmd == cmd_otp_read;
			end
			else if (!selected && phase != st_idle && decode(cmd) == op_erase
				&& !sector_lock[mem_addr[sector_lsb +: sector_idx]])
			begin
				mem_req <= 1'b1;
				mem_op <= op_erase; // RULE15 RULE14
				erase_kind <= cmd == cmd_bulk_erase ? er_bulk
					: cmd == cmd_sect_erase ? er_sect : er_sub;
			end
			if (phase == st_addr && cmd == cmd_suspend && busy)
				suspend <= 1'b1; // RULE18
			else if (phase == st_addr && cmd == cmd_resume)
				suspend <= 1'b0;
		end
	end

	// per sector volatile lock and otp lock
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sector_lock <= '0;
			otp_locked <= 1'b0;
		end
		else if (in_byte && cmd == cmd_lock_write)
			sector_lock[mem_addr[sector_lsb +: sector_idx]]
				<= mem_wdata[0]; // RULE16
		else if (in_byte && cmd == cmd_otp_prog
			&& mem_addr[5:0] == 6'(otp_bytes - 1) && !mem_wdata[0])
			otp_locked <= 1'b1; // RULE17
	end
endmodule

/* File: logic/flash_bus_pkg.sv */
// flash_bus_pkg: constants, modes and carriers for the serial flash bus
// assumes a system clock well above the serial clock it samples
package flash_bus_pkg;
	localparam int unsigned main_sectors       = 128;
	localparam int unsigned subs_per_sector    = 16;
	localparam int unsigned total_subsectors   = 2048;
	localparam int unsigned sector_bytes       = 65536;
	localparam int unsigned subsector_bytes    = 4096;
	localparam int unsigned otp_bytes          = 64;
	localparam int unsigned addr_bits          = 24;
	localparam int unsigned hold_disable_bit   = 4;
	localparam int unsigned sync_depth         = 2;
	localparam int unsigned lock_bit_index     = 6;

	localparam logic [7:0] cmd_read        = 8'h03;
	localparam logic [7:0] cmd_fast_read   = 8'h0b;
	localparam logic [7:0] cmd_dual_out    = 8'h3b;
	localparam logic [7:0] cmd_dual_io     = 8'hbb;
	localparam logic [7:0] cmd_quad_out    = 8'h6b;
	localparam logic [7:0] cmd_quad_io     = 8'heb;
	localparam logic [7:0] cmd_page_prog   = 8'h02;
	localparam logic [7:0] cmd_dual_prog   = 8'ha2;
	localparam logic [7:0] cmd_dual_xprog  = 8'hd2;
	localparam logic [7:0] cmd_quad_prog   = 8'h32;
	localparam logic [7:0] cmd_quad_xprog  = 8'h12;
	localparam logic [7:0] cmd_sub_erase   = 8'h20;
	localparam logic [7:0] cmd_sect_erase  = 8'hd8;
	localparam logic [7:0] cmd_bulk_erase  = 8'hc7;
	localparam logic [7:0] cmd_otp_read    = 8'h4b;
	localparam logic [7:0] cmd_otp_prog    = 8'h42;
	localparam logic [7:0] cmd_suspend     = 8'h75;
	localparam logic [7:0] cmd_resume      = 8'h7a;
	localparam logic [7:0] cmd_lock_write  = 8'he5;

	typedef enum logic [1:0] {
		proto_extended     = 2'h0,
		two_line_protocol  = 2'h1,
		four_line_protocol = 2'h2
	} protocol_t;

	typedef enum logic [2:0] {
		st_idle  = 3'h0,
		st_cmd   = 3'h1,
		st_addr  = 3'h3,
		st_dummy = 3'h2,
		st_data  = 3'h6,
		st_done  = 3'h7
	} phase_t;

	typedef enum logic [1:0] {
		op_none  = 2'h0,
		op_read  = 2'h1,
		op_write = 2'h2,
		op_erase = 2'h3
	} op_t;

	typedef enum logic [1:0] {
		er_sub  = 2'h0,
		er_sect = 2'h1,
		er_bulk = 2'h2
	} erase_t;

	typedef struct packed {
		logic [3:0] dq_in;
		logic       sclk;
		logic       select_n;
		logic       hold_n;
		logic       reset_n;
	} pins_t;

	typedef struct packed {
		logic [3:0] dq_out;
		logic [3:0] dq_oe;
	} drive_t;

	typedef struct packed {
		protocol_t  protocol;
		logic       execute_in_place;
		logic       hold_off;
		logic [3:0] dummy;
		logic [2:0] impedance;
		logic [1:0] wrap;
	} config_t;
endpackage

/* File: verification/serial_nor_flash_bus_asserts.sv */
// serial_nor_flash_bus_asserts: port checks of the flash bus block
// assumes binding into serial_nor_flash_bus_interface, one clock domain
`timescale 1ns/1ps
module serial_nor_flash_bus_asserts
	import flash_bus_pkg::*;
(
	input wire logic    clock,
	input wire logic    resetn,
	input wire pins_t   pins,
	input wire drive_t  drive,
	input wire config_t nonvolatile_config_reg,
	input wire logic    volatile_valid,
	input wire config_t enhanced_volatile_config_reg,
	input wire logic    busy,
	input wire logic    standby,
	input wire logic    mem_req,
	input wire logic    in_reset
);
	config_t    cfg;
	logic       sclk_q;
	logic [3:0] since_fall;
	assign cfg = volatile_valid ? enhanced_volatile_config_reg
		: nonvolatile_config_reg;
	// saturates so a long idle never wraps into the legal window
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_q     <= 1'b0;
			since_fall <= 4'hf;
		end
		else
		begin
			sclk_q <= pins.sclk;
			if (sclk_q && !pins.sclk)
				since_fall <= 4'h0;
			else if (since_fall != 4'hf)
				since_fall <= since_fall + 4'h1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_standby_idle: assert property (
		(pins.select_n && !busy)[*6] |-> standby)
		else $error("standby missing while idle");
	chk_active_select: assert property (
		(!pins.select_n)[*6] |-> !standby)
		else $error("standby while selected");
	chk_deselect_float: assert property (
		pins.select_n[*6] |-> !drive.dq_oe[1])
		else $error("line one driven while deselected");
	chk_reset_float: assert property (
		(!pins.reset_n && pins.select_n)[*6] |-> drive.dq_oe == 4'h0)
		else $error("lines driven in reset");
	chk_reset_flag: assert property (
		(!pins.reset_n && pins.select_n)[*6] |-> in_reset)
		else $error("reset pin low but no reset");
	chk_out_after_fall: assert property (
		drive.dq_oe[1] && $past(drive.dq_oe[1]) && $changed(drive.dq_out[1])
		|-> since_fall inside {[4'h1:4'h6]})
		else $error("output changed away from a clock fall");
	chk_req_pulse: assert property (
		mem_req |=> !mem_req)
		else $error("request longer than one cycle");
	chk_hold_float: assert property (
		(!pins.hold_n && !pins.select_n && !cfg.hold_off
		&& cfg.protocol != four_line_protocol)[*6] |-> !drive.dq_oe[1])
		else $error("line one driven during hold");
endmodule
bind serial_nor_flash_bus_interface serial_nor_flash_bus_asserts chk (
	.clock(clock), .resetn(resetn), .pins(pins), .drive(drive),
	.nonvolatile_config_reg(nonvolatile_config_reg),
	.volatile_valid(volatile_valid),
	.enhanced_volatile_config_reg(enhanced_volatile_config_reg),
	.busy(busy), .standby(standby), .mem_req(mem_req),
	.in_reset(in_reset));

/* File: verification/flash_host_model.sv */
// flash_host_model: behavioural host controller for the flash bus
// assumes a 5 ns clock; serial clock runs at 80 ns inside frames only
`timescale 1ns/1ps
module flash_host_model
(
	input wire logic       clock,
	input wire logic [3:0] dq_in,
	output logic           sclk,
	output logic           select_n,
	output logic [3:0]     dq_host,
	output logic [3:0]     dq_host_oe
);
	initial
	begin
		sclk       = 1'b0;
		select_n   = 1'b1;
		dq_host    = 4'h0;
		dq_host_oe = 4'h0;
	end
	task automatic half();
		repeat (8) @(posedge clock);
	endtask
	task automatic open_frame();
		select_n <= 1'b0;
		half();
	endtask
	// msb first on line zero; line one sampled on each rise
	task automatic byte_xfer(input logic [7:0] tx, input logic drv,
		output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			dq_host[0]    <= tx[i];
			dq_host_oe[0] <= drv;
			half();
			sclk  <= 1'b1;
			rx[i] = dq_in[1];
			half();
			sclk <= 1'b0;
		end
	endtask
	task automatic close_frame();
		half();
		select_n      <= 1'b1;
		dq_host_oe[0] <= 1'b0;
		half();
	endtask
endmodule

/* File: verification/serial_nor_flash_bus_interface_tb.sv */
// serial_nor_flash_bus_interface_tb: directed tests of the flash bus
// assumes the host model and checker are compiled with the design
`timescale 1ns/1ps
module serial_nor_flash_bus_interface_tb
	import flash_bus_pkg::*;
;
	localparam logic [7:0] codes [3] = '{cmd_sub_erase, cmd_sect_erase,
		cmd_bulk_erase};
	localparam erase_t kinds [3] = '{er_sub, er_sect, er_bulk};
	logic                    clock;
	logic                    resetn;
	pins_t                   pins;
	drive_t                  drive;
	config_t                 cfg;
	logic                    vvalid;
	logic                    busy;
	logic                    standby;
	logic                    mem_req;
	op_t                     mem_op;
	erase_t                  erase_kind;
	logic [addr_bits-1:0]    mem_addr;
	logic [7:0]              rdata;
	logic                    suspend;
	logic                    in_reset;
	logic                    sclk;
	logic                    select_n;
	logic                    hold_n;
	logic                    reset_pin;
	logic                    filler = 1'b0;
	logic [3:0]              dq_host;
	logic [3:0]              dq_host_oe;
	int                      reqs;
	op_t                     seen_op;
	erase_t                  seen_kind;
	logic [addr_bits-1:0]    seen_addr;
	int                      num_errors;
	int                      checked;
	logic [7:0]              rx;
	logic [7:0]              wdata;
	logic [7:0]              seen_wdata;
	logic [main_sectors-1:0] locks;
	serial_nor_flash_bus_interface uut (.clock(clock), .resetn(resetn),
		.pins(pins), .drive(drive), .nonvolatile_config_reg(cfg),
		.volatile_valid(vvalid), .enhanced_volatile_config_reg(cfg),
		.busy(busy), .standby(standby), .mem_req(mem_req),
		.mem_op(mem_op), .erase_kind(erase_kind), .mem_addr(mem_addr),
		.mem_wdata(wdata), .otp_space(), .mem_rdata(rdata),
		.suspend(suspend), .sector_lock(locks), .otp_locked(),
		.in_reset(in_reset));
	flash_host_model host (.clock(clock), .dq_in(pins.dq_in),
		.sclk(sclk), .select_n(select_n), .dq_host(dq_host),
		.dq_host_oe(dq_host_oe));
	initial clock = 1'b0;
	always #2.5 clock = ~clock;
	always @(posedge clock) filler <= ~filler;
	// released lines toggle so a stale bit never passes for data
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			pins.dq_in[i] = drive.dq_oe[i] ? drive.dq_out[i]
				: dq_host_oe[i] ? dq_host[i] : filler ^ i[0];
		pins.sclk     = sclk;
		pins.select_n = select_n;
		pins.hold_n   = hold_n;
		pins.reset_n  = reset_pin;
	end
	always @(posedge clock)
		if (mem_req === 1'b1)
		begin
			reqs      <= reqs + 1;
			seen_op   <= mem_op;
			seen_kind <= erase_kind;
			seen_addr <= mem_addr;
			seen_wdata <= wdata;
		end
	task automatic check_bit(input string what, input logic exp,
		input logic got);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic check_vec(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run_cmd(input logic [7:0] code, input logic [23:0] addr,
		input logic use_addr, input logic rd);
		logic [7:0] unused;
		host.open_frame();
		host.byte_xfer(code, 1'b1, unused);
		if (use_addr)
			for (int k = 2; k >= 0; k--)
				host.byte_xfer(addr[8*k +: 8], 1'b1, unused);
		if (rd)
			repeat (2) host.byte_xfer(8'h00, 1'b0, rx);
		host.close_frame();
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clock);
		num_errors++;
		final_report();
	end
	initial
	begin
		resetn = 1'b0;
		hold_n = 1'b1;
		reset_pin = 1'b1;
		busy = 1'b0;
		vvalid = 1'b0;
		cfg = '0;
		rdata = 8'h5a;
		num_errors = 0;
		checked = 0;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		repeat (6) @(posedge clock);
		check_vec("idle enables", 32'h0, 32'(drive.dq_oe));
		check_bit("standby idle", 1'b1, standby);
		busy <= 1'b1;
		repeat (6) @(posedge clock);
		check_bit("standby busy", 1'b0, standby);
		busy <= 1'b0;
		host.open_frame();
		check_bit("standby selected", 1'b0, standby);
		hold_n <= 1'b0;
		repeat (8) @(posedge clock);
		check_bit("line one in hold", 1'b0, drive.dq_oe[1]);
		hold_n <= 1'b1;
		host.close_frame();
		$display("test power and hold done");
		foreach (codes[k])
		begin
			run_cmd(codes[k], 24'h7f0000, k != 2, 1'b0);
			check_vec("request count", k + 1, reqs);
			check_vec("operation", op_erase, seen_op);
			check_vec("erase kind", kinds[k], seen_kind);
			if (k != 2)
				check_vec("erase address", 24'h7f0000, seen_addr);
		end
		$display("test erase done");
		host.open_frame();
		host.byte_xfer(cmd_lock_write, 1'b1, rx);
		host.byte_xfer(8'h7f, 1'b1, rx);
		repeat (2) host.byte_xfer(8'h00, 1'b1, rx);
		host.byte_xfer(8'h01, 1'b1, rx);
		host.close_frame();
		check_vec("lock request op", op_write, seen_op);
		check_vec("lock data", 8'h01, seen_wdata);
		check_bit("sector lock", 1'b1, locks[main_sectors-1]);
		run_cmd(cmd_sub_erase, 24'h7f0000, 1'b1, 1'b0);
		check_vec("locked erase count", 4, reqs);
		$display("test lock done");
		run_cmd(cmd_read, 24'h000100, 1'b1, 1'b1);
		check_vec("read byte", 8'h5a, rx);
		check_vec("read op", op_read, seen_op);
		check_vec("read address", 24'h000100, seen_addr);
		$display("test read done");
		// address only frame once the default asks for execute in place
		cfg.execute_in_place <= 1'b1;
		host.open_frame();
		host.byte_xfer(8'h00, 1'b1, rx);
		host.byte_xfer(8'h02, 1'b1, rx);
		host.byte_xfer(8'h00, 1'b1, rx);
		host.byte_xfer(8'h00, 1'b0, rx);
		host.close_frame();
		cfg.execute_in_place <= 1'b0;
		check_vec("xip read", 8'h5a, rx);
		check_vec("xip address", 24'h000200, seen_addr);
		$display("test xip done");
		busy <= 1'b1;
		run_cmd(cmd_suspend, 24'h0, 1'b0, 1'b0);
		check_bit("suspend set", 1'b1, suspend);
		run_cmd(cmd_resume, 24'h0, 1'b0, 1'b0);
		check_bit("suspend clear", 1'b0, suspend);
		busy <= 1'b0;
		$display("test suspend done");
		reset_pin <= 1'b0;
		repeat (8) @(posedge clock);
		check_bit("in reset", 1'b1, in_reset);
		check_vec("reset enables", 32'h0, 32'(drive.dq_oe));
		reset_pin <= 1'b1;
		repeat (8) @(posedge clock);
		$display("test reset pin done");
		final_report();
	end
endmodule
